//--- plh_map.svh
/*
 constants of the feedback divider, lock detector and pin selectors.
 assumes inclusion by bare name from the package; definitions only.
*/
`ifndef PLH_MAP_SVH
`define PLH_MAP_SVH

// ********
// prescaler mode codes
// ********
`define PLH_PRE_DM2  3'h0
`define PLH_PRE_DM4  3'h1
`define PLH_PRE_DM8  3'h2
`define PLH_PRE_DM16 3'h3
`define PLH_PRE_DM32 3'h4
`define PLH_PRE_FD1  3'h5
`define PLH_PRE_FD2  3'h6
`define PLH_PRE_FD3  3'h7

// ********
// lock detector counts and windows, in cycles
// ********
`define PLH_LDCNT_0      8'h05
`define PLH_LDCNT_1      8'h10
`define PLH_LDCNT_2      8'h40
`define PLH_LDCNT_3      8'hFF
`define PLH_LOCK_THR_HI  6'h04
`define PLH_LOCK_THR_LO  6'h02
`define PLH_UNLK_THR_HI  6'h08
`define PLH_UNLK_THR_LO  6'h04

// ********
// pin selector codes
// ********
`define PLH_LDSEL_DLD    6'h01
`define PLH_LDSEL_CS     6'h04
`define PLH_MON_DLD      6'h01
`define PLH_MON_CMP_HI   6'h02
`define PLH_MON_CMP_LO   6'h03

`endif

//--- plh_pkg.sv
/*
 types shared by the pll control block.
 assumes plh_map.svh sits in the same folder.
*/
`include "plh_map.svh"

package plh_pkg;

    typedef enum logic [2:0] {
        PLH_HO_RUN  = 3'b001,
        PLH_HO_HOLD = 3'b010,
        PLH_HO_WAIT = 3'b100
    } plh_ho_state_type;

    typedef struct packed {
        logic [2:0]  pre_mode;
        logic [5:0]  a_val;
        logic [12:0] b_val;
        logic [13:0] r_val;
        logic        ab_reset;
        logic        rab_reset;
        logic [1:0]  sync_mode;
        logic        r_dly_en;
        logic [2:0]  r_dly;
        logic        n_dly_en;
        logic [2:0]  n_dly;
    } plh_div_cfg_type;

    typedef struct packed {
        logic [1:0]  cnt_sel;
        logic        window;
        logic [1:0]  abp;
        logic [5:0]  ld_sel;
        logic [4:0]  mon_sel;
        logic [5:0]  stat_sel;
    } plh_lock_cfg_type;

    typedef struct packed {
        logic en_a;
        logic en_b;
        logic manual;
    } plh_ho_cfg_type;

endpackage

//--- plh_pll_control.sv
/*
 feedback divider, path delays, lock detect, lock pin muxes, manual holdover.
 assumes one-cycle tick pulses on i_clk and configuration within divider limits.
*/
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - B of one, A zero: prescaler alone divides
// - own and shared reset bits hold counters until cleared
// - low realign pin resets R, A and B when enabled
// - R and N paths each have a three-bit delay
// - lock sets after a chosen run of in-window cycles
// - lock clears only beyond the wider unlock window
// - window bit and antibacklash setting shape the windows
// - lock flag routable to lock, status and monitor pins
// - current-source mode sources while locked, else grounds
// - lock pin comparator, high or low, on status and monitor
// - holdover idles the charge pump, no up or down correction
// - holdover acts only with both holdover enable bits set
// - falling realign edge enters holdover; a held low does not
// - holdover ends on the next reference edge after pin high
// - that reference edge resets the B counter, prescaler untouched
// - feedback divide equals P times B plus A in dual-modulus modes, P times B in fixed-divide modes
// - count field zero needs five in-window cycles
module plh_pll_control
    import plh_pkg::*;
(
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic             i_vco_tick,
    input  wire logic             i_ref_tick,
    input  wire logic             i_sync_n,
    input  wire logic             i_ld_cmp,
    input  wire plh_div_cfg_type  i_div_cfg,
    input  wire plh_lock_cfg_type i_lock_cfg,
    input  wire plh_ho_cfg_type   i_ho_cfg,
    output logic                  o_ref_pfd,
    output logic                  o_fb_pfd,
    output logic                  o_pump_up,
    output logic                  o_pump_down,
    output logic                  o_cp_hiz,
    output logic                  o_digital_lock_flag,
    output logic                  o_lock_pin_out,
    output logic                  o_lock_pin_oe,
    output logic                  o_lock_source_on,
    output logic                  o_status_pin,
    output logic                  o_reference_monitor_pin
);

    // ********
    // functions
    // ********
    function automatic logic [5:0] plh_modulus(input logic [2:0] m);
        case (m)
            `PLH_PRE_DM2:  plh_modulus = 6'h02;
            `PLH_PRE_DM4:  plh_modulus = 6'h04;
            `PLH_PRE_DM8:  plh_modulus = 6'h08;
            `PLH_PRE_DM16: plh_modulus = 6'h10;
            `PLH_PRE_DM32: plh_modulus = 6'h20;
            `PLH_PRE_FD1:  plh_modulus = 6'h01;
            `PLH_PRE_FD2:  plh_modulus = 6'h02;
            default:       plh_modulus = 6'h03;
        endcase
    endfunction

    function automatic logic plh_tap(input logic raw, input logic [6:0] sh,
        input logic en, input logic [2:0] code);
        if (!en || code == 3'h0) begin
            plh_tap = raw;
        end else begin
            plh_tap = sh[code - 3'h1];
        end
    endfunction

    function automatic logic plh_mon(input logic [5:0] sel, input logic flag,
        input logic cmp);
        if (sel == `PLH_MON_DLD) begin
            plh_mon = flag;
        end else if (sel == `PLH_MON_CMP_HI) begin
            plh_mon = cmp;
        end else if (sel == `PLH_MON_CMP_LO) begin
            plh_mon = !cmp;
        end else begin
            plh_mon = 1'b0;
        end
    endfunction

    // ********
    // holdover
    // ********
    plh_ho_state_type ho_state;
    plh_ho_state_type next_ho_state;
    logic             sync_q;
    logic             ref_q;
    logic             fb_q;
    logic             ho_on;
    logic             ho_b_reset;

    always_comb begin
        ho_on         = i_ho_cfg.en_a && i_ho_cfg.en_b && i_ho_cfg.manual;
        next_ho_state = ho_state;
        ho_b_reset    = 1'b0;
        case (ho_state)
            PLH_HO_RUN: begin
                if (ho_on && sync_q && !i_sync_n) begin
                    next_ho_state = PLH_HO_HOLD;
                end
            end
            PLH_HO_HOLD: begin
                if (!ho_on) begin
                    next_ho_state = PLH_HO_RUN;
                end else if (i_sync_n) begin
                    next_ho_state = PLH_HO_WAIT;
                end
            end
            PLH_HO_WAIT: begin
                if (!ho_on) begin
                    next_ho_state = PLH_HO_RUN;
                end else if (!i_sync_n) begin
                    next_ho_state = PLH_HO_HOLD;
                end else if (ref_q) begin
                    next_ho_state = PLH_HO_RUN;
                    ho_b_reset    = 1'b1;
                end
            end
            default: begin
                next_ho_state = PLH_HO_RUN;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ho_state <= PLH_HO_RUN;
            sync_q   <= 1'b1;
        end else begin
            ho_state <= next_ho_state;
            sync_q   <= i_sync_n;
        end
    end

    assign o_cp_hiz = (ho_state != PLH_HO_RUN);

    // ********
    // r and n dividers
    // ********
    logic [5:0]  pre_cnt;
    logic [5:0]  next_pre_cnt;
    logic [5:0]  a_cnt;
    logic [5:0]  next_a_cnt;
    logic [12:0] b_cnt;
    logic [12:0] next_b_cnt;
    logic [13:0] r_cnt;
    logic [13:0] next_r_cnt;
    logic        fb_raw;
    logic        next_fb_raw;
    logic        ref_raw;
    logic        next_ref_raw;
    logic        dm;
    logic [5:0]  pmod;
    logic [12:0] b_last;
    logic [13:0] r_last;
    logic        sync_rst;

    always_comb begin
        dm           = (i_div_cfg.pre_mode < `PLH_PRE_FD1);
        // fixed-divide modes ignore A; dual modulus adds one while A runs
        pmod         = plh_modulus(i_div_cfg.pre_mode);
        if (dm && a_cnt < i_div_cfg.a_val) begin
            pmod = pmod + 6'h01;
        end
        // a B of zero or one is the bypass, the prescaler alone divides
        b_last       = (i_div_cfg.b_val <= 13'h0001) ? 13'h0000
            : i_div_cfg.b_val - 13'h0001;
        r_last       = (i_div_cfg.r_val <= 14'h0001) ? 14'h0000
            : i_div_cfg.r_val - 14'h0001;
        sync_rst     = !i_sync_n && (i_div_cfg.sync_mode != 2'h0);
        next_pre_cnt = pre_cnt;
        next_a_cnt   = a_cnt;
        next_b_cnt   = b_cnt;
        next_r_cnt   = r_cnt;
        next_fb_raw  = 1'b0;
        next_ref_raw = 1'b0;
        if (i_vco_tick) begin
            if (pre_cnt >= pmod - 6'h01) begin
                next_pre_cnt = 6'h00;
                if (b_cnt >= b_last) begin
                    next_b_cnt  = 13'h0000;
                    next_a_cnt  = 6'h00;
                    next_fb_raw = 1'b1;
                end else begin
                    next_b_cnt = b_cnt + 13'h0001;
                    if (a_cnt != 6'h3F) begin
                        next_a_cnt = a_cnt + 6'h01;
                    end
                end
            end else begin
                next_pre_cnt = pre_cnt + 6'h01;
            end
        end
        if (i_ref_tick) begin
            if (r_cnt >= r_last) begin
                next_r_cnt   = 14'h0000;
                next_ref_raw = 1'b1;
            end else begin
                next_r_cnt = r_cnt + 14'h0001;
            end
        end
        if (ho_b_reset) begin
            next_b_cnt = 13'h0000;
        end
        if (i_div_cfg.ab_reset || i_div_cfg.rab_reset || sync_rst) begin
            next_a_cnt  = 6'h00;
            next_b_cnt  = 13'h0000;
            next_fb_raw = 1'b0;
        end
        if (i_div_cfg.rab_reset || sync_rst) begin
            next_r_cnt   = 14'h0000;
            next_ref_raw = 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pre_cnt <= 6'h00;
            a_cnt   <= 6'h00;
            b_cnt   <= 13'h0000;
            r_cnt   <= 14'h0000;
            fb_raw  <= 1'b0;
            ref_raw <= 1'b0;
        end else begin
            pre_cnt <= next_pre_cnt;
            a_cnt   <= next_a_cnt;
            b_cnt   <= next_b_cnt;
            r_cnt   <= next_r_cnt;
            fb_raw  <= next_fb_raw;
            ref_raw <= next_ref_raw;
        end
    end

    // ********
    // path delays
    // ********
    logic [6:0] r_sh;
    logic [6:0] n_sh;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            r_sh  <= 7'h00;
            n_sh  <= 7'h00;
            ref_q <= 1'b0;
            fb_q  <= 1'b0;
        end else begin
            r_sh  <= {r_sh[5:0], ref_raw};
            n_sh  <= {n_sh[5:0], fb_raw};
            ref_q <= plh_tap(ref_raw, r_sh, i_div_cfg.r_dly_en, i_div_cfg.r_dly);
            fb_q  <= plh_tap(fb_raw, n_sh, i_div_cfg.n_dly_en, i_div_cfg.n_dly);
        end
    end

    assign o_ref_pfd = ref_q;
    assign o_fb_pfd  = fb_q;

    // ********
    // phase detector and lock detect
    // ********
    logic       ref_pend;
    logic       next_ref_pend;
    logic       fb_pend;
    logic       next_fb_pend;
    logic [5:0] dcnt;
    logic [5:0] next_dcnt;
    logic [7:0] lock_cnt;
    logic [7:0] next_lock_cnt;
    logic       lock_flag;
    logic       next_lock_flag;
    logic       meas;
    logic [5:0] diff;
    logic [5:0] lock_thr;
    logic [5:0] unlk_thr;
    logic [7:0] need;

    always_comb begin
        lock_thr = (i_lock_cfg.window ? `PLH_LOCK_THR_LO : `PLH_LOCK_THR_HI)
                   + {4'h0, i_lock_cfg.abp};
        unlk_thr = (i_lock_cfg.window ? `PLH_UNLK_THR_LO : `PLH_UNLK_THR_HI)
                   + {4'h0, i_lock_cfg.abp};
        case (i_lock_cfg.cnt_sel)
            2'h0:    need = `PLH_LDCNT_0;
            2'h1:    need = `PLH_LDCNT_1;
            2'h2:    need = `PLH_LDCNT_2;
            default: need = `PLH_LDCNT_3;
        endcase
        next_ref_pend  = ref_pend;
        next_fb_pend   = fb_pend;
        next_dcnt      = dcnt;
        next_lock_cnt  = lock_cnt;
        next_lock_flag = lock_flag;
        meas           = 1'b0;
        diff           = dcnt;
        if ((ref_q && fb_q) || (ref_q && fb_pend) || (fb_q && ref_pend)) begin
            meas          = 1'b1;
            diff          = (ref_q && fb_q) ? 6'h00 : dcnt;
            next_ref_pend = 1'b0;
            next_fb_pend  = 1'b0;
        end else if (ref_q || fb_q) begin
            next_ref_pend = ref_q;
            next_fb_pend  = fb_q;
            next_dcnt     = 6'h01;
        end else if ((ref_pend || fb_pend) && dcnt != 6'h3F) begin
            next_dcnt = dcnt + 6'h01;
        end
        // a lone edge waiting past the unlock window counts as an unlock
        if (!meas && (ref_pend || fb_pend) && dcnt > unlk_thr) begin
            meas = 1'b1;
            diff = dcnt;
        end
        if (meas) begin
            if (diff < lock_thr) begin
                if (lock_cnt != 8'hFF) begin
                    next_lock_cnt = lock_cnt + 8'h01;
                end
                if (lock_cnt >= need - 8'h01) begin
                    next_lock_flag = 1'b1;
                end
            end else begin
                next_lock_cnt = 8'h00;
                if (diff > unlk_thr) begin
                    next_lock_flag = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ref_pend    <= 1'b0;
            fb_pend     <= 1'b0;
            dcnt        <= 6'h00;
            lock_cnt    <= 8'h00;
            lock_flag   <= 1'b0;
            o_pump_up   <= 1'b0;
            o_pump_down <= 1'b0;
        end else begin
            ref_pend    <= next_ref_pend;
            fb_pend     <= next_fb_pend;
            dcnt        <= next_dcnt;
            lock_cnt    <= next_lock_cnt;
            lock_flag   <= next_lock_flag;
            o_pump_up   <= next_ref_pend && (next_ho_state == PLH_HO_RUN);
            o_pump_down <= next_fb_pend && (next_ho_state == PLH_HO_RUN);
        end
    end

    assign o_digital_lock_flag = lock_flag;

    // ********
    // pin multiplexers
    // ********
    logic next_ld_out;
    logic next_ld_oe;
    logic next_ld_src;

    always_comb begin
        next_ld_out = 1'b0;
        next_ld_oe  = 1'b0;
        next_ld_src = 1'b0;
        if (i_lock_cfg.ld_sel == `PLH_LDSEL_DLD) begin
            next_ld_out = lock_flag;
            next_ld_oe  = 1'b1;
        end else if (i_lock_cfg.ld_sel == `PLH_LDSEL_CS) begin
            // grounding at once on any false discharges the external capacitor
            next_ld_src = lock_flag;
            next_ld_oe  = !lock_flag;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_lock_pin_out          <= 1'b0;
            o_lock_pin_oe           <= 1'b0;
            o_lock_source_on        <= 1'b0;
            o_status_pin            <= 1'b0;
            o_reference_monitor_pin <= 1'b0;
        end else begin
            o_lock_pin_out          <= next_ld_out;
            o_lock_pin_oe           <= next_ld_oe;
            o_lock_source_on        <= next_ld_src;
            o_status_pin            <= plh_mon(i_lock_cfg.stat_sel, lock_flag,
                i_ld_cmp);
            o_reference_monitor_pin <= plh_mon({1'b0, i_lock_cfg.mon_sel}, lock_flag,
                i_ld_cmp);
        end
    end

endmodule

`default_nettype wire

//--- plh_pll_control_asserts.sv
/*
 port checker of the pll control block.
 assumes it is bound onto plh_pll_control by the bench.
*/
`timescale 1ns/10ps
`default_nettype none
`include "plh_map.svh"
module plh_pll_control_asserts
    import plh_pkg::*;
(
    input wire logic             i_clk,
    input wire logic             i_rst,
    input wire logic             i_sync_n,
    input wire logic             i_ld_cmp,
    input wire plh_div_cfg_type  i_div_cfg,
    input wire plh_lock_cfg_type i_lock_cfg,
    input wire plh_ho_cfg_type   i_ho_cfg,
    input wire logic             o_ref_pfd,
    input wire logic             o_fb_pfd,
    input wire logic             o_pump_up,
    input wire logic             o_pump_down,
    input wire logic             o_cp_hiz,
    input wire logic             o_digital_lock_flag,
    input wire logic             o_lock_pin_out,
    input wire logic             o_lock_pin_oe,
    input wire logic             o_lock_source_on,
    input wire logic             o_status_pin,
    input wire logic             o_reference_monitor_pin
);
    // ********
    // helper logic
    // ********
    logic [3:0] hold_cnt;
    logic [3:0] next_hold_cnt;
    logic       ho_en;
    assign ho_en = i_ho_cfg.en_a && i_ho_cfg.en_b && i_ho_cfg.manual;
    // held-cycle count, long enough to flush the delay pipeline
    always_comb begin
        next_hold_cnt = hold_cnt;
        if (i_rst || !i_div_cfg.rab_reset) begin
            next_hold_cnt = 4'h0;
        end else if (hold_cnt != 4'hF) begin
            next_hold_cnt = hold_cnt + 4'h1;
        end
    end
    always_ff @(posedge i_clk) begin
        hold_cnt <= next_hold_cnt;
    end
    // ********
    // properties
    // ********
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    chk_hiz_pumps: assert property (o_cp_hiz |-> !o_pump_up && !o_pump_down)
        else $error("pump active in holdover");
    chk_ho_gate: assert property ($rose(o_cp_hiz) |-> $past(ho_en))
        else $error("holdover without enables");
    chk_ho_entry: assert property (!o_cp_hiz && ho_en && $fell(i_sync_n) && !$past(i_rst)
        |=> o_cp_hiz) else $error("falling edge missed holdover");
    chk_ho_stay: assert property (o_cp_hiz && !i_sync_n && ho_en && !o_ref_pfd
        |=> o_cp_hiz) else $error("holdover left while pin low");
    chk_ho_exit: assert property ($fell(o_cp_hiz) && !$past(i_rst)
        |-> $past(o_ref_pfd) || !$past(ho_en)) else $error("holdover left without ref edge");
    chk_lock_edge: assert property ($rose(o_digital_lock_flag) && !$past(i_rst)
        |-> $past(o_ref_pfd || o_fb_pfd)) else $error("lock set without edge");
    chk_ld_drive: assert property ($past(i_lock_cfg.ld_sel) == `PLH_LDSEL_DLD
        && $stable(o_digital_lock_flag) && !$past(i_rst)
        |-> o_lock_pin_oe && o_lock_pin_out == o_digital_lock_flag)
        else $error("lock pin does not follow flag");
    chk_cs_mode: assert property ($past(i_lock_cfg.ld_sel) == `PLH_LDSEL_CS
        && $stable(o_digital_lock_flag) && !$past(i_rst)
        |-> o_lock_source_on == o_digital_lock_flag && o_lock_pin_oe == !o_digital_lock_flag
        && !o_lock_pin_out) else $error("current source mode wrong");
    chk_stat_cmp: assert property ($past(i_lock_cfg.stat_sel) == `PLH_MON_CMP_LO
        && !$past(i_rst) |-> o_status_pin == !$past(i_ld_cmp))
        else $error("status pin not inverted comparator");
    chk_mon_flag: assert property ($past(i_lock_cfg.mon_sel) == `PLH_MON_DLD
        && $stable(o_digital_lock_flag) && !$past(i_rst)
        |-> o_reference_monitor_pin == o_digital_lock_flag) else $error("monitor pin wrong");
    chk_rab_hold: assert property (hold_cnt >= 4'hA |-> !o_ref_pfd && !o_fb_pfd)
        else $error("edge while counters held");
    cov_lock: cover property ($rose(o_digital_lock_flag));
    cov_hold: cover property ($rose(o_cp_hiz));
    cov_source: cover property (o_lock_source_on);
endmodule
`default_nettype wire

//--- plh_tick_src.sv
/*
 reference and vco edge model: ref edge on command, vco edge after a skew.
 assumes commands spaced wider than the skew.
*/
`timescale 1ns/10ps
`default_nettype none
module plh_tick_src (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_fire,
    input  wire logic [3:0] i_skew,
    input  wire logic       i_vco_free,
    output logic            o_ref_tick,
    output logic            o_vco_tick
);
    logic [3:0] left;
    // skew kept below the pair spacing
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_ref_tick <= 1'b0;
            o_vco_tick <= 1'b0;
            left <= 4'h0;
        end else begin
            o_ref_tick <= i_fire;
            o_vco_tick <= i_vco_free || (i_fire && i_skew == 4'h0) || left == 4'h1;
            if (i_fire && i_skew != 4'h0) begin
                left <= i_skew;
            end else if (left != 4'h0) begin
                left <= left - 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

//--- testbench.sv
/*
 self-checking bench of the pll control block.
 assumes the package, the tick source model and the checker compile first.
*/
`timescale 1ns/10ps
`default_nettype none
`include "plh_map.svh"
module testbench
    import plh_pkg::*;
;
    typedef struct packed {
        logic [2:0]  pre;
        logic [5:0]  a;
        logic [12:0] b;
        logic [15:0] n;
    } plh_row_type;
    logic clk, rst, fire, vco_free, sync_n, ld_cmp, ref_tick, vco_tick;
    logic ref_pfd, fb_pfd, pump_up, pump_down, cp_hiz, flag, ld_out, ld_oe, src_on, stat, mon;
    logic [3:0]       skew;
    logic [15:0]      n, tr, tf;
    plh_div_cfg_type  div_cfg;
    plh_lock_cfg_type lock_cfg;
    plh_ho_cfg_type   ho_cfg;
    int               fail_count, tests_run;
    logic [7:0]       need [4] = '{`PLH_LDCNT_0, `PLH_LDCNT_1, `PLH_LDCNT_2, `PLH_LDCNT_3};
    plh_row_type      rows [10] = '{
        '{`PLH_PRE_FD1, 6'h00, 13'h0003, 16'h0003}, '{`PLH_PRE_FD2, 6'h05, 13'h0003, 16'h0006},
        '{`PLH_PRE_DM2, 6'h00, 13'h0003, 16'h0006}, '{`PLH_PRE_DM2, 6'h01, 13'h0003, 16'h0007},
        '{`PLH_PRE_DM4, 6'h00, 13'h0001, 16'h0004}, '{`PLH_PRE_FD1, 6'h00, 13'h0001, 16'h0001},
        '{`PLH_PRE_FD3, 6'h00, 13'h0001, 16'h0003}, '{`PLH_PRE_DM8, 6'h06, 13'h0012, 16'h0096},
        '{`PLH_PRE_DM16, 6'h07, 13'h0009, 16'h0097}, '{`PLH_PRE_DM32, 6'h00, 13'h0001, 16'h0020}};
    plh_tick_src i_src (.i_clk(clk), .i_rst(rst), .i_fire(fire), .i_skew(skew),
        .i_vco_free(vco_free), .o_ref_tick(ref_tick), .o_vco_tick(vco_tick));
    plh_pll_control i_dut (.i_clk(clk), .i_rst(rst), .i_vco_tick(vco_tick), .i_ref_tick(ref_tick),
        .i_sync_n(sync_n), .i_ld_cmp(ld_cmp), .i_div_cfg(div_cfg), .i_lock_cfg(lock_cfg),
        .i_ho_cfg(ho_cfg), .o_ref_pfd(ref_pfd), .o_fb_pfd(fb_pfd), .o_pump_up(pump_up),
        .o_pump_down(pump_down), .o_cp_hiz(cp_hiz), .o_digital_lock_flag(flag),
        .o_lock_pin_out(ld_out), .o_lock_pin_oe(ld_oe), .o_lock_source_on(src_on),
        .o_status_pin(stat), .o_reference_monitor_pin(mon));
    // ********
    // tasks
    // ********
    task automatic cmp1(input logic got, input logic exp);
        cmpn(16'(got), 16'(exp));
    endtask
    task automatic cmpn(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask
    // edge pair every 21 cycles, above the unlock window
    task automatic pair(input logic [3:0] s);
        @(posedge clk);
        fire <= 1'b1;
        skew <= s;
        cyc(1);
        fire <= 1'b0;
        cyc(19);
    endtask
    // cycles to the next feedback edge, capped at 0x200
    task automatic per(output logic [15:0] v);
        v = 16'h0000;
        do begin
            @(posedge clk);
            #1 v++;
        end while (fb_pfd !== 1'b1 && v < 16'h0200);
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ********
    // clock, watchdog, sequence
    // ********
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        #3000000;
        fail_count++;
        wrap_up();
    end
    initial begin
        {rst, fire, vco_free, sync_n, ld_cmp, skew} = {1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 4'h0};
        div_cfg = '0;
        div_cfg.r_val = 14'h0001;
        lock_cfg = '0;
        ho_cfg = '0;
        cyc(5);
        rst <= 1'b0;
        #1 cmp1(cp_hiz, 1'b0);
        cmp1(flag, 1'b0);
        @(posedge clk);
        vco_free <= 1'b1;
        foreach (rows[i]) begin
            @(posedge clk);
            {div_cfg.pre_mode, div_cfg.a_val, div_cfg.b_val} <= {rows[i].pre, rows[i].a, rows[i].b};
            per(n);
            per(n);
            per(n);
            cmpn(n, rows[i].n);
        end
        // counter holds: dedicated bit, shared bit, realign pin
        for (int c = 0; c < 3; c++) begin
            @(posedge clk);
            {div_cfg.b_val, div_cfg.ab_reset, div_cfg.rab_reset} <= {13'h0003, c == 0, c == 1};
            {div_cfg.sync_mode, sync_n} <= {(c == 2) ? 2'h1 : 2'h0, c != 2};
            cyc(12);
            per(n);
            cmpn(n, 16'h0200);
        end
        @(posedge clk);
        {div_cfg.ab_reset, div_cfg.rab_reset, div_cfg.sync_mode, sync_n} <= 5'h01;
        {vco_free, div_cfg.b_val, div_cfg.pre_mode} <= {1'b0, 13'h0001, `PLH_PRE_FD1};
        // path delays: off, then ref code 2 and feedback code 5
        for (int c = 0; c < 2; c++) begin
            @(posedge clk);
            {div_cfg.r_dly_en, div_cfg.r_dly, div_cfg.n_dly_en, div_cfg.n_dly} <= {c[0], 3'h2, c[0], 3'h5};
            pair(4'h0);
            @(posedge clk);
            fire <= 1'b1;
            cyc(1);
            fire <= 1'b0;
            {tr, tf} = 32'h0;
            for (int k = 1; k < 16; k++) begin
                #1 if (ref_pfd === 1'b1) tr = 16'(k);
                if (fb_pfd === 1'b1) tf = 16'(k);
                if (k == 7) cmp1(pump_up, c[0]);
                if (k == 7) cmp1(pump_down, 1'b0);
                cyc(1);
            end
            cmpn(tr, 16'(3 + 2 * c));
            cmpn(tf, 16'(3 + 5 * c));
        end
        @(posedge clk);
        {div_cfg.r_dly_en, div_cfg.n_dly_en} <= 2'h0;
        // every count code; skew 3 sits just inside the window
        for (int c = 0; c < 4; c++) begin
            @(posedge clk);
            lock_cfg.cnt_sel <= 2'(c);
            pair(4'hA);
            for (int k = 1; k < need[c]; k++) pair(4'h0);
            #1 cmp1(flag, 1'b0);
            pair(4'h3);
            #1 cmp1(flag, 1'b1);
        end
        @(posedge clk);
        lock_cfg.cnt_sel <= 2'h0;
        pair(4'h6);
        pair(4'h8);
        #1 cmp1(flag, 1'b1);
        pair(4'h9);
        #1 cmp1(flag, 1'b0);
        for (int k = 0; k < 9; k++) pair((k == 4) ? 4'h5 : 4'h0);
        #1 cmp1(flag, 1'b0);
        pair(4'h0);
        #1 cmp1(flag, 1'b1);
        pair(4'h9);
        @(posedge clk);
        lock_cfg.window <= 1'b1;
        repeat (5) pair(4'h3);
        #1 cmp1(flag, 1'b0);
        @(posedge clk);
        lock_cfg.abp <= 2'h2;
        repeat (5) pair(4'h3);
        #1 cmp1(flag, 1'b1);
        // pin selectors, locked then unlocked
        @(posedge clk);
        {lock_cfg.ld_sel, lock_cfg.stat_sel, lock_cfg.mon_sel} <= {`PLH_LDSEL_CS, `PLH_MON_CMP_LO, 5'h01};
        ld_cmp <= 1'b1;
        cyc(3);
        #1 cmp1(src_on, 1'b1);
        cmp1(ld_oe, 1'b0);
        cmp1(stat, 1'b0);
        cmp1(mon, 1'b1);
        pair(4'hC);
        #1 cmp1(src_on, 1'b0);
        cmp1(ld_oe, 1'b1);
        cmp1(ld_out, 1'b0);
        @(posedge clk);
        {lock_cfg.ld_sel, lock_cfg.stat_sel, lock_cfg.mon_sel} <= {`PLH_LDSEL_DLD, `PLH_MON_DLD, 5'h02};
        cyc(3);
        #1 cmp1(ld_oe, 1'b1);
        cmp1(stat, 1'b0);
        cmp1(mon, 1'b1);
        // manual holdover
        @(posedge clk);
        ho_cfg <= 3'b101;
        sync_n <= 1'b0;
        cyc(3);
        #1 cmp1(cp_hiz, 1'b0);
        @(posedge clk);
        {sync_n, ho_cfg.en_b} <= 2'b11;
        cyc(2);
        sync_n <= 1'b0;
        cyc(2);
        #1 cmp1(cp_hiz, 1'b1);
        pair(4'h0);
        #1 cmp1(cp_hiz, 1'b1);
        @(posedge clk);
        sync_n <= 1'b1;
        cyc(30);
        #1 cmp1(cp_hiz, 1'b1);
        pair(4'h0);
        #1 cmp1(cp_hiz, 1'b0);
        // reset in mid-holdover
        @(posedge clk);
        sync_n <= 1'b0;
        cyc(3);
        {rst, sync_n} <= 2'b11;
        cyc(1);
        rst <= 1'b0;
        #1 cmp1(cp_hiz, 1'b0);
        cmp1(flag, 1'b0);
        wrap_up();
    end
endmodule
bind plh_pll_control plh_pll_control_asserts i_chk (.i_clk, .i_rst, .i_sync_n, .i_ld_cmp,
    .i_div_cfg, .i_lock_cfg, .i_ho_cfg, .o_ref_pfd, .o_fb_pfd, .o_pump_up, .o_pump_down,
    .o_cp_hiz, .o_digital_lock_flag, .o_lock_pin_out, .o_lock_pin_oe, .o_lock_source_on,
    .o_status_pin, .o_reference_monitor_pin);
`default_nettype wire
